/* File: verilog/fsw_status.sv */
// Status registers and write protection of a serial flash, driven from the SPI pins.
// What this block does
// - Power-on reset blocks every instruction.
// - Write instructions wait out power-up delay.
// - Write enable sets the write permit latch.
// - Latch clears on power-up and write instructions.
// - Busy set during work; only status read, suspend.
// - Busy clears when work completes.
// - Deep power-down accepts only release instruction.
// - Range bits S4..S2 written by status write.
// - Range bits default to zero.
// - S5 selects top or bottom start.
// - S6 selects sector or block granularity.
// - Lock bits S8,S7 select protection mode.
// - Locks 00: write allowed with latch set.
// - Locks 01, pin low and four-line enable off: refused.
// - Locks 01 and pin high: allowed.
// - Locks 10: refused until power cycle clears.
// - Locks 11: refused until power cycle clears.
// - Suspend sets halted flag; resume clears it.
// - Four-line enable turns pins into data.
// - Write instructions need whole bytes at deselect.
`timescale 1ns/10ps
`include "fsw_cfg.svh"
module fsw_status #(
	parameter int PUW_CYCLES = `FSW_PUW_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        cs_n_pin,
	input  wire logic        sclk_pin,
	input  wire logic        di_pin,
	input  wire logic        wp_n_pin,
	output logic             do_out,
	output logic             do_oe_n,
	output logic [7:0]       status_low,
	output logic [7:0]       status_high,
	output logic             pin_wp_active,
	output logic             pin_io_quad,
	output logic             power_down
);
	logic                  cs_n_s;
	logic                  sclk_s;
	logic                  di_s;
	logic                  wp_n_s;
	logic                  sclk_d_reg;
	logic                  cs_d_reg;
	logic [`FSW_CNT_W-1:0] puw_cnt_reg;
	logic                  puw_done_reg;
	logic [2:0]            bit_cnt_reg;
	logic [7:0]            shift_reg;
	logic [7:0]            opcode_reg;
	logic [4:0]            byte_cnt_reg;
	logic [15:0]           wdata_reg;
	fsw_pkg::fsw_ser_type  ser_reg;
	fsw_pkg::fsw_op_type   op_reg;
	logic [`FSW_CNT_W-1:0] work_cnt_reg;
	logic                  work_is_sr_reg;
	logic [15:0]           work_data_reg;
	logic                  wpl_reg;
	logic                  halt_reg;
	logic                  dpd_reg;
	logic [7:0]            out_sh_reg;
	logic                  out_hi_reg;
	logic [15:0]           nv_q;
	logic                  nv_wr;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  cs_rise;
	logic                  cs_fall;
	logic                  byte_done;
	logic                  whole_bytes;
	logic                  sr_allowed;
	logic                  busy;

	// Pins come from the host's clock domain and pass the three-stage synchroniser.
	fsw_sync u_sync_cs (.clk_sys(clk_sys), .arst_n(arst_n), .init_val(1'b1), .pin_in(cs_n_pin), .level_out(cs_n_s));
	fsw_sync u_sync_ck (.clk_sys(clk_sys), .arst_n(arst_n), .init_val(1'b0), .pin_in(sclk_pin), .level_out(sclk_s));
	fsw_sync u_sync_di (.clk_sys(clk_sys), .arst_n(arst_n), .init_val(1'b0), .pin_in(di_pin), .level_out(di_s));
	fsw_sync u_sync_wp (.clk_sys(clk_sys), .arst_n(arst_n), .init_val(1'b1), .pin_in(wp_n_pin), .level_out(wp_n_s));

	// Non-volatile range, lock and four-line bits live in the store.
	fsw_nvstore u_nv (.clk_sys(clk_sys), .arst_n(arst_n), .wr_en(nv_wr), .wr_data(work_data_reg), .rd_data(nv_q));

	// Edge detection on the synchronised levels.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			cs_d_reg   <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
	assign cs_rise   = cs_n_s & ~cs_d_reg;
	assign cs_fall   = ~cs_n_s & cs_d_reg;
	assign byte_done = sclk_rise && bit_cnt_reg == 3'd7;

	// Power-up write delay; write-type instructions wait for it.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			puw_cnt_reg  <= '0;
			puw_done_reg <= 1'b0;
		end else if (!puw_done_reg) begin
			puw_cnt_reg <= puw_cnt_reg + 1'b1;
			if (puw_cnt_reg >= `FSW_CNT_W'(PUW_CYCLES - 1))
				puw_done_reg <= 1'b1;
		end
	end

	// Bit and byte counting on host clock rises, MSB first.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_reg  <= 3'd0;
			shift_reg    <= 8'h00;
			byte_cnt_reg <= 5'd0;
		end else if (cs_n_s) begin
			bit_cnt_reg  <= 3'd0;
			byte_cnt_reg <= 5'd0;
		end else if (sclk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'd1;
			shift_reg   <= {shift_reg[6:0], di_s};
			if (bit_cnt_reg == 3'd7 && byte_cnt_reg != 5'd31)
				byte_cnt_reg <= byte_cnt_reg + 5'd1;
		end
	end

	// Frame sequencer: opcode byte, then data bytes, or ignore the rest.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ser_reg    <= fsw_pkg::FSW_IDLE;
			opcode_reg <= 8'h00;
			wdata_reg  <= 16'h0000;
		end else begin
			case (ser_reg)
				fsw_pkg::FSW_IDLE: begin
					if (cs_fall)
						ser_reg <= fsw_pkg::FSW_OPCODE;
				end
				fsw_pkg::FSW_OPCODE: begin
					if (cs_n_s)
						ser_reg <= fsw_pkg::FSW_IDLE;
					else if (byte_done) begin
						opcode_reg <= {shift_reg[6:0], di_s};
						ser_reg    <= fsw_pkg::FSW_DATA;
					end
				end
				fsw_pkg::FSW_DATA: begin
					if (cs_n_s)
						ser_reg <= fsw_pkg::FSW_IDLE;
					else if (byte_done && byte_cnt_reg == 5'd1)
						wdata_reg[7:0] <= {shift_reg[6:0], di_s};
					else if (byte_done && byte_cnt_reg == 5'd2)
						wdata_reg[15:8] <= {shift_reg[6:0], di_s};
				end
				fsw_pkg::FSW_IGNORE: begin
					if (cs_n_s)
						ser_reg <= fsw_pkg::FSW_IDLE;
				end
				default: ser_reg <= fsw_pkg::FSW_IDLE;
			endcase
		end
	end

	// Write instructions only count when deselected on a byte boundary.
	assign whole_bytes = (bit_cnt_reg == 3'd0);
	assign busy        = (op_reg == fsw_pkg::FSW_WORKING);

	// Lock-mode decision for the status write.
	always_comb begin
		case ({nv_q[`FSW_B_LOCK1], nv_q[`FSW_B_LOCK0]})
			2'b00:   sr_allowed = wpl_reg;
			2'b01:   sr_allowed = wpl_reg & (wp_n_s | nv_q[`FSW_B_QE]);
			2'b10:   sr_allowed = 1'b0;
			default: sr_allowed = 1'b0;
		endcase
	end

	// Instruction execution at deselect; busy gates everything but suspend, power-down everything but release.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			op_reg         <= fsw_pkg::FSW_READY;
			work_cnt_reg   <= '0;
			work_is_sr_reg <= 1'b0;
			work_data_reg  <= 16'h0000;
			wpl_reg        <= 1'b0;
			halt_reg       <= 1'b0;
			dpd_reg        <= 1'b0;
		end else begin
			if (busy) begin
				if (work_cnt_reg == `FSW_WORK_CYC - 16'd1) begin
					op_reg <= fsw_pkg::FSW_READY;
					work_cnt_reg <= '0;
				end else begin
					work_cnt_reg <= work_cnt_reg + 16'd1;
				end
				if (cs_rise && ser_reg == fsw_pkg::FSW_DATA && opcode_reg == `FSW_OP_SUSP) begin
					halt_reg <= 1'b1;
					op_reg   <= fsw_pkg::FSW_READY;
					work_cnt_reg <= '0;
				end
			end else if (cs_rise && ser_reg == fsw_pkg::FSW_DATA && puw_done_reg) begin
				if (dpd_reg) begin
					if (opcode_reg == `FSW_OP_RDPD)
						dpd_reg <= 1'b0;
				end else begin
					case (opcode_reg)
						`FSW_OP_WREN: if (whole_bytes) wpl_reg <= 1'b1;
						`FSW_OP_WRDI: if (whole_bytes) wpl_reg <= 1'b0;
						`FSW_OP_DPD:  dpd_reg <= 1'b1;
						`FSW_OP_RESM: halt_reg <= 1'b0;
						`FSW_OP_WRSR: begin
							if (whole_bytes && sr_allowed && byte_cnt_reg >= 5'd2) begin
								op_reg         <= fsw_pkg::FSW_WORKING;
								work_is_sr_reg <= 1'b1;
								work_data_reg  <= (byte_cnt_reg >= 5'd3) ? wdata_reg
									: {nv_q[15:8], wdata_reg[7:0]};
								wpl_reg        <= 1'b0;
							end
						end
						`FSW_OP_PP, `FSW_OP_SE, `FSW_OP_BE64, `FSW_OP_BE32, `FSW_OP_CE1, `FSW_OP_CE2: begin
							if (whole_bytes && wpl_reg) begin
								op_reg         <= fsw_pkg::FSW_WORKING;
								work_is_sr_reg <= 1'b0;
								wpl_reg        <= 1'b0;
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// The store is written once as the status write finishes its busy time.
	assign nv_wr = busy && work_is_sr_reg && work_cnt_reg == `FSW_WORK_CYC - 16'd1;

	// Status bytes: reserved bits read zero, defaults come from the store reset.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_low  <= 8'h00;
			status_high <= 8'h00;
		end else begin
			status_low  <= {nv_q[7:2], wpl_reg, busy};
			status_high <= {halt_reg, 5'h00, nv_q[`FSW_B_QE], nv_q[`FSW_B_LOCK1]};
		end
	end

	// Status read shifts out on host clock falls; the byte repeats while selected.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			out_sh_reg <= 8'h00;
			out_hi_reg <= 1'b0;
			do_oe_n    <= 1'b1;
		end else if (cs_n_s || dpd_reg) begin
			do_oe_n <= 1'b1;
		end else if (byte_done && ser_reg == fsw_pkg::FSW_OPCODE) begin
			out_hi_reg <= ({shift_reg[6:0], di_s} == `FSW_OP_RDSR_HI);
			do_oe_n    <= ~({shift_reg[6:0], di_s} == `FSW_OP_RDSR_HI
				|| {shift_reg[6:0], di_s} == `FSW_OP_RDSR_LO);
			out_sh_reg <= ({shift_reg[6:0], di_s} == `FSW_OP_RDSR_HI) ? status_high : status_low;
		end else if (sclk_fall && !do_oe_n) begin
			if (bit_cnt_reg == 3'd0)
				out_sh_reg <= out_hi_reg ? status_high : status_low;
			else
				out_sh_reg <= {out_sh_reg[6:0], 1'b0};
		end
	end
	assign do_out = out_sh_reg[7];

	// Pin function flags for the pad logic.
	assign pin_io_quad   = nv_q[`FSW_B_QE];
	assign pin_wp_active = ~nv_q[`FSW_B_QE] & ~wp_n_s;
	assign power_down    = dpd_reg;

	property p_busy_len;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(busy) |-> busy [*8];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("Busy dropped too early.");

	property p_refused;
		@(posedge clk_sys) disable iff (!arst_n)
		(!busy && cs_rise && ser_reg == fsw_pkg::FSW_DATA && opcode_reg == `FSW_OP_WRSR && !sr_allowed)
		|=> !busy;
	endproperty
	a_refused: assert property (p_refused) else $error("Refused status write set busy.");

	property p_lock_perm;
		@(posedge clk_sys) disable iff (!arst_n)
		nv_q[`FSW_B_LOCK1] |-> !sr_allowed;
	endproperty
	a_lock_perm: assert property (p_lock_perm) else $error("Locked status write allowed.");

	property p_hw_lock;
		@(posedge clk_sys) disable iff (!arst_n)
		(nv_q[`FSW_B_LOCK0] && !nv_q[`FSW_B_LOCK1] && !wp_n_s && !nv_q[`FSW_B_QE]) |-> !sr_allowed;
	endproperty
	a_hw_lock: assert property (p_hw_lock) else $error("Write-protect pin ignored.");

	property p_puw;
		@(posedge clk_sys) disable iff (!arst_n)
		!puw_done_reg |=> !wpl_reg;
	endproperty
	a_puw: assert property (p_puw) else $error("Latch set during power-up delay.");

	property p_wpl_clr;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(busy) |-> !wpl_reg;
	endproperty
	a_wpl_clr: assert property (p_wpl_clr) else $error("Latch not cleared by write.");

	property p_dpd;
		@(posedge clk_sys) disable iff (!arst_n)
		dpd_reg |=> $stable(wpl_reg) && !$rose(busy);
	endproperty
	a_dpd: assert property (p_dpd) else $error("Instruction acted in power-down.");

	property p_done;
		@(posedge clk_sys) disable iff (!arst_n)
		nv_wr |=> !busy;
	endproperty
	a_done: assert property (p_done) else $error("Busy stuck after completion.");

	c_sr_write: cover property (@(posedge clk_sys) disable iff (!arst_n) nv_wr);
	c_suspend:  cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(halt_reg));
	c_dpd:      cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(dpd_reg));
endmodule // fsw_status

/* File: verilog/fsw_cfg.svh */
// Constants for the flash status and write-protect block.
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
`define FSW_OP_WREN     8'h06
`define FSW_OP_WRDI     8'h04
`define FSW_OP_RDSR_LO  8'h05
`define FSW_OP_RDSR_HI  8'h35
`define FSW_OP_WRSR     8'h01
`define FSW_OP_PP       8'h02
`define FSW_OP_SE       8'h20
`define FSW_OP_BE64     8'hD8
`define FSW_OP_BE32     8'h52
`define FSW_OP_CE1      8'hC7
`define FSW_OP_CE2      8'h60
`define FSW_OP_SUSP     8'h75
`define FSW_OP_RESM     8'h7A
`define FSW_OP_DPD      8'hB9
`define FSW_OP_RDPD     8'hAB
`define FSW_OP_SECW     8'h42
`define FSW_B_BUSY      0
`define FSW_B_WPL       1
`define FSW_B_LOCK0     7
`define FSW_B_LOCK1     8
`define FSW_B_QE        9
`define FSW_B_HALT      15
`define FSW_NV_RESET    16'h0000
`define FSW_NV_MASK     16'h03FC
`define FSW_PUW_NS      32'd10000
`define FSW_CLK_NS      32'd10
`define FSW_PUW_CYC     (`FSW_PUW_NS / `FSW_CLK_NS)
`define FSW_WORK_CYC    16'd200
`define FSW_CNT_W       16
`endif

/* File: verilog/fsw_pkg.sv */
// Types shared by the flash status and write-protect block.
package fsw_pkg;
	typedef enum logic [2:0] {FSW_IDLE, FSW_OPCODE, FSW_DATA, FSW_IGNORE} fsw_ser_type;
	typedef enum logic [1:0] {FSW_READY, FSW_WORKING} fsw_op_type;
endpackage

/* File: verilog/fsw_sync.sv */
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/10ps
module fsw_sync (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic init_val,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// The first stage is read only by the second to keep metastability contained.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Marks which stages already hold a real pin sample, so the reset zeros are never taken as a level.
	logic [2:0] fill_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fill_reg <= 3'h0;
		end else begin
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	// The level changes only once the second and third stages agree.
	// Until both stages carry pin samples the idle value is shown, which avoids a false edge after reset.
	logic lvl_reg;
	logic seen_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			lvl_reg  <= 1'b0;
			seen_reg <= 1'b0;
		end else if (fill_reg[2] && s2_reg == s3_reg) begin
			lvl_reg  <= s3_reg;
			seen_reg <= 1'b1;
		end
	end

	assign level_out = seen_reg ? lvl_reg : init_val;
endmodule // fsw_sync

/* File: verilog/fsw_nvstore.sv */
// Small store for the non-volatile status bits, read data registered.
`timescale 1ns/10ps
`include "fsw_cfg.svh"
module fsw_nvstore (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] rd_data
);
	logic [15:0] cell_reg;

	// Cells hold the factory default until written; only documented bits persist.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cell_reg <= `FSW_NV_RESET;
		end else if (wr_en) begin
			cell_reg <= wr_data & `FSW_NV_MASK | wr_data & (16'h0001 << `FSW_B_LOCK0)
				| wr_data & (16'h0001 << `FSW_B_LOCK1) | wr_data & (16'h0001 << `FSW_B_QE);
		end
	end

	// Read port is a register so the status bytes come from flops.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= `FSW_NV_RESET;
		end else begin
			rd_data <= cell_reg;
		end
	end
endmodule // fsw_nvstore

/* File: test/fsw_host_model.sv */
// Behavioural SPI host that frames serial flash instructions for the bench.
`timescale 1ns/10ps
module fsw_host_model (
	output logic        cs_n_pin,
	output logic        sclk_pin,
	output logic        di_pin,
	input  wire logic   do_out,
	input  wire logic   do_oe_n,
	output logic [15:0] rx
);
	// Deselected with the clock parked low, as in mode 0.
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b0;
		di_pin = 1'b0;
		rx = 16'h0000;
	end

	// Sends the low nbits of d MSB first at a 125 ns bit time and collects read data on each rise.
	// The small lead-in keeps pin changes away from the system clock edges.
	task automatic frame(input logic [23:0] d, input int nbits);
		#2 cs_n_pin = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			di_pin = d[i];
			#62.5 sclk_pin = 1'b1;
			rx = {rx[14:0], do_oe_n ? 1'b1 : do_out};
			#62.5 sclk_pin = 1'b0;
		end
		#62.5 cs_n_pin = 1'b1;
		di_pin = ~di_pin;
		#250;
	endtask
endmodule // fsw_host_model

/* File: test/test_fsw_status.sv */
// Self-checking bench for the flash status and write-protect block.
`timescale 1ns/10ps
`include "fsw_cfg.svh"
module test_fsw_status;
	localparam int PUW = 300;
	logic        clk_sys;
	logic        arst_n;
	logic        wp_n_pin;
	logic        cs_n_pin;
	logic        sclk_pin;
	logic        di_pin;
	logic        do_out;
	logic        do_oe_n;
	logic [7:0]  status_low;
	logic [7:0]  status_high;
	logic        pin_wp_active;
	logic        pin_io_quad;
	logic        power_down;
	logic [15:0] rx;
	logic [15:0] st;
	int          n_errors = 0;
	int          comparisons = 0;

	// Block under test and the host on its serial side.
	fsw_status #(.PUW_CYCLES(PUW)) fsw_status_i (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .di_pin(di_pin), .wp_n_pin(wp_n_pin), .do_out(do_out), .do_oe_n(do_oe_n),
		.status_low(status_low), .status_high(status_high), .pin_wp_active(pin_wp_active),
		.pin_io_quad(pin_io_quad), .power_down(power_down));
	fsw_host_model fsw_host_model_i (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .di_pin(di_pin),
		.do_out(do_out), .do_oe_n(do_oe_n), .rx(rx));

	// System clock at 100 MHz.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Compares and counts.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Instruction helpers built on the host's frame task.
	task automatic op(input logic [7:0] c);
		fsw_host_model_i.frame({16'h0000, c}, 8);
	endtask

	task automatic wrsr(input logic [7:0] lo, input logic [7:0] hi);
		op(`FSW_OP_WREN);
		fsw_host_model_i.frame({`FSW_OP_WRSR, lo, hi}, 24);
	endtask

	task automatic rd_status(output logic [15:0] s);
		fsw_host_model_i.frame({8'h00, `FSW_OP_RDSR_LO, 8'h00}, 16);
		s[7:0] = rx[7:0];
		fsw_host_model_i.frame({8'h00, `FSW_OP_RDSR_HI, 8'h00}, 16);
		s[15:8] = rx[7:0];
	endtask

	// Bounded wait for busy to drop; a hang counts as a mismatch.
	task automatic wait_idle();
		int k;
		k = 0;
		while (status_low[`FSW_B_BUSY] !== 1'b0 && k < 400) begin
			@(negedge clk_sys);
			k++;
		end
		// The stored bits reach the status bytes two cycles after busy drops.
		repeat (3) @(negedge clk_sys);
		if (k == 400) begin
			n_errors++;
			close_out();
		end
	endtask

	// Reset held across a whole write enable, then the power-up delay waited out.
	task automatic power_cycle();
		@(negedge clk_sys);
		arst_n = 1'b0;
		op(`FSW_OP_WREN);
		@(negedge clk_sys);
		arst_n = 1'b1;
		repeat (PUW + 20) @(negedge clk_sys);
		chk({status_high, status_low}, 16'h0000);
	endtask

	// Defaults, and a write enable sent inside the power-up delay.
	task automatic t_defaults();
		op(`FSW_OP_WREN);
		chk({status_high, status_low}, 16'h0000);
		chk({13'h0000, do_oe_n, power_down, pin_io_quad}, 16'h0004);
		repeat (PUW) @(negedge clk_sys);
		op(`FSW_OP_WREN);
		chk({8'h00, status_low}, 16'h0002);
		op(`FSW_OP_WRDI);
		chk({8'h00, status_low}, 16'h0000);
	endtask

	// Status write with an ignored write enable during busy, a read back, and a cut-off byte.
	task automatic t_write();
		@(negedge clk_sys);
		wp_n_pin = 1'b0;
		wrsr(8'h7C, 8'h00);
		chk({8'h00, status_low}, 16'h0001);
		op(`FSW_OP_WREN);
		wait_idle();
		chk({status_high, status_low}, 16'h007C);
		rd_status(st);
		chk(st, 16'h007C);
		op(`FSW_OP_WREN);
		fsw_host_model_i.frame({4'h0, `FSW_OP_WRSR, 12'h000}, 20);
		chk({8'h00, status_low}, 16'h007E);
		wrsr(8'h00, 8'h00);
		wait_idle();
		chk({status_high, status_low}, 16'h0000);
	endtask

	// Each lock mode against the protect pin.
	task automatic t_locks();
		wrsr(8'h80, 8'h00);
		wait_idle();
		wrsr(8'h84, 8'h00);
		chk({status_high, status_low} & 16'hFFFD, 16'h0080);
		chk({15'h0000, pin_wp_active}, 16'h0001);
		@(negedge clk_sys);
		wp_n_pin = 1'b1;
		wrsr(8'h84, 8'h00);
		wait_idle();
		chk({status_high, status_low}, 16'h0084);
		wrsr(8'h00, 8'h01);
		wait_idle();
		wrsr(8'h04, 8'h00);
		chk({status_high, status_low} & 16'hFFFD, 16'h0100);
		power_cycle();
		wrsr(8'h80, 8'h01);
		wait_idle();
		wrsr(8'h00, 8'h00);
		chk({status_high, status_low} & 16'hFFFD, 16'h0180);
		power_cycle();
	endtask

	// Suspend in mid-write, then resume.
	task automatic t_suspend();
		wrsr(8'h04, 8'h00);
		op(`FSW_OP_SUSP);
		chk({14'h0000, status_high[7], status_low[0]}, 16'h0002);
		op(`FSW_OP_RESM);
		chk({15'h0000, status_high[7]}, 16'h0000);
		wait_idle();
	endtask

	// Deep power-down ignores a write enable until release.
	task automatic t_dpd();
		op(`FSW_OP_DPD);
		op(`FSW_OP_WREN);
		chk({14'h0000, power_down, status_low[1]}, 16'h0002);
		op(`FSW_OP_RDPD);
		op(`FSW_OP_WREN);
		chk({14'h0000, power_down, status_low[1]}, 16'h0001);
		op(`FSW_OP_WRDI);
	endtask

	// Four-line enable hands the protect pin over to data.
	task automatic t_quad();
		wrsr(8'h80, 8'h02);
		wait_idle();
		// The pin is driven by the bench, never tied to a rail.
		@(negedge clk_sys);
		wp_n_pin = 1'b0;
		chk({14'h0000, pin_io_quad, pin_wp_active}, 16'h0002);
		wrsr(8'h84, 8'h02);
		wait_idle();
		chk({status_high, status_low}, 16'h0284);
	endtask

	// Main sequence.
	initial begin
		arst_n = 1'b0;
		wp_n_pin = 1'b1;
		repeat (6) @(negedge clk_sys);
		arst_n = 1'b1;
		t_defaults();
		t_write();
		t_locks();
		t_suspend();
		t_dpd();
		t_quad();
		close_out();
	end

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_errors++;
		close_out();
	end
endmodule // test_fsw_status
